// ===== src/reset_cause_register.sv
`timescale 1ns/10ps
`default_nettype none
`include "rcs_cfg.svh"

// Function
// - flash error sets read-only bit 6
// - bit 5 comparator reset enable and flag
// - writing bit 4 forces system reset
// - bit 4 reads 1 after software reset
// - watchdog overflow sets read-only bit 3
// - bit 2 missing-clock enable and flag
// - bit 1 write enables supply monitor
// - bit 1 set on power-on/monitor reset
// - reset pin sets read-only bit 0
// - writing 0 disables missing-clock detector
// - internal resets never drive reset pin
module reset_cause_register
  import rcs_pkg::*;
#(
  parameter logic [`RCS_CNT_W-1:0] HOLD_CYCLES =
    `RCS_CNT_W'((`RCS_HOLD_NS + `RCS_CLK_NS - 1) / `RCS_CLK_NS)
)(
  // clock and power-on reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // special-function register port
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_page_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  // asynchronous reset sources
  input  wire logic       rst_pin_n_i,
  input  wire logic       cmp_out_i,
  input  wire logic       mcd_timeout_i,
  input  wire logic       vdd_ok_i,
  // synchronous reset sources
  input  wire logic       wdt_reset_i,
  input  wire logic       flash_err_i,
  // source enables and system reset
  output logic            cmp_reset_en_o,
  output logic            mcd_en_o,
  output logic            vdd_reset_en_o,
  output logic            sys_rst_n_o
);
  core_state_t q;
  core_state_t nxt_q;
  logic        hit;
  logic        wr;
  logic        rd;
  logic [7:0]  src;
  logic        level_src;
  logic        wr_cmp_en;
  logic        wr_mcd_en;
  logic        wr_vdd_en;
  logic        wr_sw_force;

  rst_sync_if sy ();

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  // outside levels cross into the clock domain here
  rst_input_sync rst_input_sync_inst (
    .mclk_i        (mclk_i),
    .rst_n_i       (rst_n_i),
    .rst_pin_n_i   (rst_pin_n_i),
    .cmp_out_i     (cmp_out_i),
    .mcd_timeout_i (mcd_timeout_i),
    .vdd_ok_i      (vdd_ok_i),
    .sy            (sy.drv)
  );

  // ----------------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] p);
    addr_hit = (a == `RCS_ADDR) && (p == `RCS_PAGE);
  endfunction

  always_comb begin
    hit = 1'b0;
    if (addr_hit(sfr_addr_i, sfr_page_i)) begin
      hit = 1'b1;
    end
  end

  // writes are only honoured while the core runs
  assign wr = sfr_wr_i && hit && (q.state == ST_RUN);
  // reads are harmless at any time; rdata drops back to zero after one cycle
  assign rd = sfr_rd_i && hit;

  // ----------------------------------------------------------------------
  // write field decode; bits 7, 6, 3 and 0 are read-only
  // ----------------------------------------------------------------------
  always_comb begin
    wr_cmp_en   = sfr_wdata_i[`RCS_CMP_BIT];
    wr_mcd_en   = sfr_wdata_i[`RCS_MCD_BIT];
    wr_vdd_en   = sfr_wdata_i[`RCS_POR_BIT];
    wr_sw_force = wr & sfr_wdata_i[`RCS_SW_BIT];
  end

  // ----------------------------------------------------------------------
  // reset source collection
  // ----------------------------------------------------------------------
  always_comb begin
    src                = 8'h00;
    src[`RCS_PIN_BIT]  = ~sy.pin_n;
    src[`RCS_POR_BIT]  = q.vdd_en & ~sy.vdd_ok;
    src[`RCS_MCD_BIT]  = q.mcd_en & sy.mcd_timeout;
    src[`RCS_WDT_BIT]  = wdt_reset_i;
    src[`RCS_SW_BIT]   = wr_sw_force;
    src[`RCS_CMP_BIT]  = q.cmp_en & ~sy.cmp_out;
    src[`RCS_FERR_BIT] = flash_err_i;
  end

  // sources that stretch the reset for as long as they persist
  assign level_src = src[`RCS_PIN_BIT] | src[`RCS_POR_BIT] | src[`RCS_MCD_BIT];

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------
  // a power-on or supply cause hides every other cause
  function automatic logic [7:0] capture_flags(input logic [7:0] p);
    logic [7:0] f;
    if (p[`RCS_POR_BIT]) begin
      f = `RCS_POR_ONLY;
    end else begin
      f = p;
    end
    f[`RCS_UNUSED_BIT] = 1'b0;
    capture_flags = f;
  endfunction

  // values loaded by the power-on reset; flags read power-on once released
  function automatic core_state_t reset_state();
    core_state_t r;
    r.state     = ST_HOLD;
    r.cnt       = HOLD_CYCLES;
    r.flags     = `RCS_FLAGS_RST;
    r.pend      = `RCS_POR_ONLY;
    r.cmp_en    = 1'b0;
    r.mcd_en    = 1'b0;
    r.vdd_en    = `RCS_VDD_EN_RST;
    r.sys_rst_n = 1'b0;
    r.rdata     = 8'h00;
    reset_state = r;
  endfunction

  // ----------------------------------------------------------------------
  // sequencer and register next state
  // ----------------------------------------------------------------------
  // pin, supply and missing-clock levels keep reloading the hold counter;
  // pulsed causes only start it
  always_comb begin
    nxt_q       = q;
    nxt_q.rdata = 8'h00;
    case (q.state)
      ST_RUN: begin
        if (wr) begin
          nxt_q.cmp_en = wr_cmp_en;
          nxt_q.mcd_en = wr_mcd_en;
          nxt_q.vdd_en = wr_vdd_en;
        end
        if (|src) begin
          // system reset asserted at the next edge
          nxt_q.state     = ST_HOLD;
          nxt_q.pend      = src;
          nxt_q.cnt       = HOLD_CYCLES;
          nxt_q.sys_rst_n = 1'b0;
        end
      end
      ST_HOLD: begin
        // causes that arrive during the hold are merged
        nxt_q.pend = q.pend | src;
        if (level_src) begin
          nxt_q.cnt = HOLD_CYCLES;
        end else if (q.cnt > `RCS_CNT_ONE) begin
          nxt_q.cnt = q.cnt - `RCS_CNT_ONE;
        end else begin
          // flags captured at release, held until the next release or power-on reset
          nxt_q.state     = ST_RUN;
          nxt_q.sys_rst_n = 1'b1;
          nxt_q.flags     = capture_flags(q.pend);
          nxt_q.pend      = `RCS_FLAGS_RST;
          // supply enable survives system resets; the other two do not
          nxt_q.cmp_en    = 1'b0;
          nxt_q.mcd_en    = 1'b0;
        end
      end
      default: begin
        nxt_q.state = ST_HOLD;
      end
    endcase
    if (rd) begin
      // reads show causes, not enables; bit 7 reads zero
      nxt_q.rdata = {1'b0, q.flags[`RCS_FERR_BIT:`RCS_PIN_BIT]};
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      q <= reset_state();
    end else begin
      q <= nxt_q;
    end
  end

  // ----------------------------------------------------------------------
  // outputs; the reset pin is input only and never driven
  // ----------------------------------------------------------------------
  assign sfr_rdata_o    = q.rdata;
  assign cmp_reset_en_o = q.cmp_en;
  assign mcd_en_o       = q.mcd_en;
  assign vdd_reset_en_o = q.vdd_en;
  assign sys_rst_n_o    = q.sys_rst_n;
endmodule
`default_nettype wire

// ===== src/rcs_cfg.svh
`ifndef RCS_CFG_SVH
`define RCS_CFG_SVH

// ----------------------------------------------------------------------
// register location in the special-function space
// ----------------------------------------------------------------------
`define RCS_ADDR        8'hef
`define RCS_PAGE        8'h00

// ----------------------------------------------------------------------
// bit positions of reset_cause_status
// ----------------------------------------------------------------------
`define RCS_PIN_BIT     0
`define RCS_POR_BIT     1
`define RCS_MCD_BIT     2
`define RCS_WDT_BIT     3
`define RCS_SW_BIT      4
`define RCS_CMP_BIT     5
`define RCS_FERR_BIT    6
`define RCS_UNUSED_BIT  7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RCS_FLAGS_RST   8'h00
`define RCS_POR_ONLY    8'h02
`define RCS_VDD_EN_RST  1'b1
`define RCS_SYNC_INIT   4'hb
`define RCS_CNT_W       16

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define RCS_HOLD_NS     100
`define RCS_CLK_NS      20
`define RCS_CNT_ONE     16'h0001

`endif

// ===== src/rcs_pkg.sv
package rcs_pkg;
  `include "rcs_cfg.svh"

  typedef enum logic [0:0] {
    ST_RUN  = 1'b0,
    ST_HOLD = 1'b1
  } seq_state_t;

  typedef struct packed {
    seq_state_t              state;
    logic [`RCS_CNT_W-1:0]   cnt;
    logic [7:0]              flags;
    logic [7:0]              pend;
    logic                    cmp_en;
    logic                    mcd_en;
    logic                    vdd_en;
    logic                    sys_rst_n;
    logic [7:0]              rdata;
  } core_state_t;

  // vector order: {vdd_ok, mcd_timeout, cmp_out, pin_n}
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] q;
  } sync_state_t;
endpackage

// ===== src/rst_sync_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rst_sync_if;
  logic pin_n;
  logic cmp_out;
  logic mcd_timeout;
  logic vdd_ok;

  modport drv  (output pin_n, output cmp_out, output mcd_timeout, output vdd_ok);
  modport core (input  pin_n, input  cmp_out, input  mcd_timeout, input  vdd_ok);
endinterface
`default_nettype wire

// ===== src/rst_input_sync.sv
`timescale 1ns/10ps
`default_nettype none
`include "rcs_cfg.svh"

module rst_input_sync
  import rcs_pkg::*;
(
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // raw asynchronous inputs
  input  wire logic rst_pin_n_i,
  input  wire logic cmp_out_i,
  input  wire logic mcd_timeout_i,
  input  wire logic vdd_ok_i,
  // filtered levels
  rst_sync_if.drv   sy
);
  sync_state_t q;
  sync_state_t nxt_q;

  // ----------------------------------------------------------------------
  // three stages; a level is taken once stages two and three agree
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_q    = q;
    nxt_q.s1 = {vdd_ok_i, mcd_timeout_i, cmp_out_i, rst_pin_n_i};
    nxt_q.s2 = q.s1;
    nxt_q.s3 = q.s2;
    for (int i = 0; i < 4; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        nxt_q.q[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      q <= {4{`RCS_SYNC_INIT}};
    end else begin
      q <= nxt_q;
    end
  end

  assign sy.pin_n       = q.q[0];
  assign sy.cmp_out     = q.q[1];
  assign sy.mcd_timeout = q.q[2];
  assign sy.vdd_ok      = q.q[3];
endmodule
`default_nettype wire

// ===== tb/rcs_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
module rcs_chk
  import rcs_pkg::*;
#(
  parameter logic [15:0] HOLD_CYCLES = 16'h0005
)(
  // clock and register port
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_page_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  // sources and results
  input wire logic       vdd_ok_i,
  input wire logic       wdt_reset_i,
  input wire logic       flash_err_i,
  input wire logic       cmp_reset_en_o,
  input wire logic       mcd_en_o,
  input wire logic       vdd_reset_en_o,
  input wire logic       sys_rst_n_o
);
  logic        wr_ok;
  logic        wr_cfg;
  logic [15:0] lo_cnt_ff;
  assign wr_ok  = sfr_wr_i && sfr_addr_i == 8'hef && sfr_page_i == 8'h00 && sys_rst_n_o;
  assign wr_cfg = wr_ok && !sfr_wdata_i[4] && !wdt_reset_i && !flash_err_i;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || sys_rst_n_o)
      lo_cnt_ff <= 16'h0000;
    else
      lo_cnt_ff <= lo_cnt_ff + 16'h0001;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_sw_force_rst: assert property (wr_ok && sfr_wdata_i[4] |=> !sys_rst_n_o)
    else $error("software write gave no reset");
  a_wdt_rst_now: assert property (wdt_reset_i && sys_rst_n_o |=> !sys_rst_n_o)
    else $error("watchdog gave no reset");
  a_flash_rst_now: assert property (flash_err_i && sys_rst_n_o |=> !sys_rst_n_o)
    else $error("flash error gave no reset");
  a_cmp_en_set: assert property (wr_cfg && sfr_wdata_i[5] |=> cmp_reset_en_o)
    else $error("comparator enable not set");
  a_mcd_en_set: assert property (wr_cfg && sfr_wdata_i[2] |=> mcd_en_o)
    else $error("missing clock enable not set");
  a_mcd_en_clear: assert property (wr_cfg && !sfr_wdata_i[2] |=> !mcd_en_o)
    else $error("missing clock enable not cleared");
  a_vdd_en_clear: assert property (wr_cfg && !sfr_wdata_i[1] |=> !vdd_reset_en_o)
    else $error("supply enable not cleared");
  a_bit7_zero: assert property (sfr_rdata_o[7] == 1'b0)
    else $error("bit 7 read as one");
  a_hold_min_len: assert property ($rose(sys_rst_n_o) |-> lo_cnt_ff >= HOLD_CYCLES)
    else $error("system reset too short");
  a_vdd_drop_rst: assert property (!vdd_ok_i && vdd_reset_en_o && sys_rst_n_o
    |-> ##[1:6] !sys_rst_n_o)
    else $error("supply drop gave no reset");
endmodule
`default_nettype wire

// ===== tb/rst_src_model.sv
`timescale 1ns/10ps
`default_nettype none
module rst_src_model
  import rcs_pkg::*;
(
  // clock
  input  wire logic mclk_i,
  // reset sources
  output wire logic pin_n_o,
  output wire logic cmp_o,
  output wire logic mcd_o,
  output wire logic vdd_ok_o,
  output wire logic wdt_o,
  output wire logic ferr_o
);
  logic [5:0] act = 6'h00;
  // pin is only pulled low from outside, pull-up level otherwise
  assign pin_n_o  = !act[2];
  assign cmp_o    = !act[3];
  assign mcd_o    = act[4];
  assign vdd_ok_o = !act[5];
  assign wdt_o    = act[0];
  assign ferr_o   = act[1];
  task automatic fire(input int k);
    @(posedge mclk_i);
    act <= 6'(1 << k);
    repeat (4) @(posedge mclk_i);
    act <= 6'h00;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import rcs_pkg::*;
;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] page = 8'h00;
  logic [7:0] rdata;
  logic       pin_n, cmp, missing_clock_detector, vdd_ok, wdt, ferr, cmp_en, mcd_en, vdd_en, sys_n;
  int         err_count = 0;
  int         checks_done = 0;
  always #10 mclk = ~mclk;
  reset_cause_register reset_cause_register_inst (.mclk_i(mclk), .rst_n_i(rst_n),
    .sfr_addr_i(addr), .sfr_page_i(page), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .rst_pin_n_i(pin_n), .cmp_out_i(cmp),
    .mcd_timeout_i(missing_clock_detector), .vdd_ok_i(vdd_ok), .wdt_reset_i(wdt), .flash_err_i(ferr),
    .cmp_reset_en_o(cmp_en), .mcd_en_o(mcd_en), .vdd_reset_en_o(vdd_en), .sys_rst_n_o(sys_n));
  rst_src_model rst_src_model_inst (.mclk_i(mclk), .pin_n_o(pin_n), .cmp_o(cmp), .mcd_o(missing_clock_detector),
    .vdd_ok_o(vdd_ok), .wdt_o(wdt), .ferr_o(ferr));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_sys(input logic v);
    int n;
    n = 0;
    while (sys_n !== v && n < 200) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (sys_n !== v) begin
      err_count++;
      $display("BAD t=%0t reset wait ran out", $time);
      finish_test();
    end
  endtask
  // whole-byte access, never read-modify-write
  task automatic sfr(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic t_cause(input int k, input logic [7:0] en, input logic [7:0] exp);
    logic [7:0] q;
    if (en != 8'h00)
      sfr(8'hef, 1'b1, en, q);
    if (k < 6)
      rst_src_model_inst.fire(k);
    else
      sfr(8'hef, 1'b1, 8'h10, q);
    wait_sys(1'b0);
    wait_sys(1'b1);
    sfr(8'hef, 1'b0, 8'h00, q);
    chk(q, exp);
    $display("cause %0d done", k);
  endtask
  task automatic t_writes(input logic [7:0] flags);
    logic [7:0] q;
    sfr(8'hef, 1'b1, 8'hec, q);
    chk({5'h00, cmp_en, mcd_en, vdd_en}, 8'h06);
    sfr(8'hef, 1'b1, 8'h22, q);
    chk({5'h00, cmp_en, mcd_en, vdd_en}, 8'h05);
    sfr(8'hef, 1'b0, 8'h00, q);
    chk(q, flags);
    sfr(8'hee, 1'b1, 8'h10, q);
    sfr(8'hee, 1'b0, 8'h00, q);
    chk({q[7:1], sys_n}, 8'h01);
    chk(q, 8'h00);
    @(posedge mclk);
    page <= 8'h0f;
    sfr(8'hef, 1'b1, 8'h10, q);
    sfr(8'hef, 1'b0, 8'h00, q);
    chk(q, 8'h00);
    chk({7'h00, sys_n}, 8'h01);
    @(posedge mclk);
    page <= 8'h00;
    $display("writes done");
  endtask
  initial begin
    logic [7:0] q;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    wait_sys(1'b1);
    sfr(8'hef, 1'b0, 8'h00, q);
    chk(q, 8'h02);
    chk({5'h00, cmp_en, mcd_en, vdd_en}, 8'h01);
    t_cause(6, 8'h00, 8'h10);
    t_cause(0, 8'h00, 8'h08);
    t_cause(1, 8'h00, 8'h40);
    t_cause(2, 8'h00, 8'h01);
    t_writes(8'h01);
    t_cause(3, 8'h20, 8'h20);
    t_cause(4, 8'h04, 8'h04);
    t_cause(5, 8'h02, 8'h02);
    finish_test();
  end
endmodule
bind reset_cause_register rcs_chk #(.HOLD_CYCLES(HOLD_CYCLES)) rcs_chk_inst (.mclk_i(mclk_i),
  .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_page_i(sfr_page_i), .sfr_wr_i(sfr_wr_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .vdd_ok_i(vdd_ok_i),
  .wdt_reset_i(wdt_reset_i), .flash_err_i(flash_err_i), .cmp_reset_en_o(cmp_reset_en_o),
  .mcd_en_o(mcd_en_o), .vdd_reset_en_o(vdd_reset_en_o), .sys_rst_n_o(sys_rst_n_o));
`default_nettype wire
